// >>> logic/npc_page_control.sv
/*
 * NAND page control: setup and trigger registers, block page sequencer,
 * chip-enable control and address/single-read launch pulses.
 * Assumes a strobe engine that answers each byte request with byte_ack,
 * and a transmit FIFO that reports tx_has_data.
 */
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module npc_page_control
   import npc_pkg::*;
#(
   parameter int ECC_BYTES = 3
) (
   // Clock and reset
   input  wire  logic        hclk,
   input  wire  logic        hresetn,
   // AHB-Lite slave
   input  wire  logic        hsel,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic [31:0] hwdata,
   input  wire  logic        hready,
   output var   logic        hreadyout,
   output var   logic        hresp,
   output var   logic [31:0] hrdata,
   // Block transfer handshake
   input  wire  logic        tx_has_data,
   input  wire  logic        byte_ack,
   output var   logic        byte_req,
   output var   logic        byte_dir_write,
   output var   logic        ecc_active,
   output var   logic        ecc_block_end,
   output var   logic        page_write_done,
   output var   logic        page_read_done,
   // Flash control
   output var   logic [3:0]  ce_n,
   output var   logic        pads_enable,
   output var   logic [27:0] timing_cfg,
   // Command-side launches
   input  wire  logic [15:0] sread_data,
   output var   logic        sread_start,
   output var   logic        addr_start,
   output var   logic [3:0]  addr_bytes
);

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   if (ECC_BYTES < 1 || ECC_BYTES > 16) begin : g_bad_ecc
      $error("ECC_BYTES must lie in 1..16");
   end

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [31:0] timing;
      logic [31:0] setup;
      logic [31:0] addr_lo;
      logic [31:0] addr_hi;
      logic        ce_on;
      logic        wr_armed;
      npc_state_t  state;
      logic [17:0] count;
      logic [17:0] total;
      logic        wdone_flag;
      logic        rdone_flag;
      logic        byte_req;
      logic        byte_dir_write;
      logic        ecc_block_end;
      logic        wr_done;
      logic        rd_done;
      logic [3:0]  ce_n;
      logic        pads_en;
      logic        sread_start;
      logic        addr_start;
      logic [3:0]  addr_bytes;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] hrdata;
   } npc_regs_t;

   npc_regs_t cur;
   npc_regs_t next_cur;

   // Page + check-code + spare bytes of one block transfer
   function automatic logic [17:0] npc_total(input logic [31:0] s);
      logic [15:0] page;
      logic [7:0]  spare;
      logic [17:0] ecc;
      page  = s[NPC_PAGE_LSB +: 16];
      spare = s[NPC_SPARE_LSB +: 8];
      ecc   = '0;
      if (s[NPC_ECCEN_BIT]) begin
         ecc = 18'(int'(page >> NPC_ECC_SHIFT) * ECC_BYTES);
      end
      return 18'(page) + 18'(spare) + ecc;
   endfunction

   logic       acc;
   logic [7:0] a_off;
   logic       if_en;
   logic [3:0] asize;
   logic       w_trig;

   assign acc    = hsel && hready && htrans[1];
   assign a_off  = haddr[7:0];
   assign if_en  = cur.setup[NPC_IFEN_BIT];
   assign asize  = cur.setup[NPC_ASIZE_LSB +: 4];
   assign w_trig = cur.wr_pend && cur.wr_addr == NPC_A_TRIG;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_cur = cur;
      next_cur.ecc_block_end = 1'b0;
      next_cur.wr_done       = 1'b0;
      next_cur.rd_done       = 1'b0;
      next_cur.sread_start   = 1'b0;
      next_cur.addr_start    = 1'b0;
      next_cur.wr_pend       = acc && hwrite;
      next_cur.wr_addr       = a_off;

      // Read data for the coming data phase
      next_cur.hrdata = '0;
      if (acc && !hwrite) begin
         if (a_off == NPC_A_TIMING) begin
            next_cur.hrdata = cur.timing;
         end else if (a_off == NPC_A_SETUP) begin
            next_cur.hrdata = cur.setup;
         end else if (a_off == NPC_A_TRIG) begin
            next_cur.hrdata = '0;
         end else if (a_off == NPC_A_ADDR) begin
            next_cur.hrdata = cur.addr_lo;
         end else if (a_off == NPC_A_ADDRX) begin
            next_cur.hrdata = cur.addr_hi;
         end else if (a_off == NPC_A_SREAD) begin
            if (cur.setup[NPC_RDEN_BIT] && if_en) begin
               next_cur.sread_start = 1'b1;
               next_cur.hrdata      = {16'h0000, sread_data};
            end
         end else if (a_off == NPC_A_STATUS) begin
            next_cur.hrdata[NPC_ST_BUSY]         = cur.state != NPC_IDLE;
            next_cur.hrdata[NPC_ST_WDONE]        = cur.wdone_flag;
            next_cur.hrdata[NPC_ST_RDONE]        = cur.rdone_flag;
            next_cur.hrdata[NPC_ST_CE_LSB +: 4]  = ~cur.ce_n;
            next_cur.hrdata[NPC_ST_CNT_LSB +: 18] = cur.count;
         end
      end

      // Register writes in the data phase
      if (cur.wr_pend) begin
         if (cur.wr_addr == NPC_A_TIMING) begin
            next_cur.timing = hwdata;
         end else if (cur.wr_addr == NPC_A_SETUP) begin
            next_cur.setup = hwdata;
         end else if (cur.wr_addr == NPC_A_ADDR) begin
            next_cur.addr_lo = hwdata;
            if (if_en && asize <= NPC_ADDR_DIRECT) begin
               next_cur.addr_start = 1'b1;
               next_cur.addr_bytes = asize;
            end
         end else if (cur.wr_addr == NPC_A_ADDRX) begin
            next_cur.addr_hi = hwdata;
            if (if_en && asize > NPC_ADDR_DIRECT) begin
               next_cur.addr_start = 1'b1;
               next_cur.addr_bytes = asize;
            end
         end else if (cur.wr_addr == NPC_A_STATUS) begin
            if (hwdata[NPC_ST_WDONE]) next_cur.wdone_flag = 1'b0;
            if (hwdata[NPC_ST_RDONE]) next_cur.rdone_flag = 1'b0;
         end
      end

      // Triggers act once; zero bits do nothing
      if (w_trig) begin
         if (hwdata[NPC_TRIG_CEON]) next_cur.ce_on = 1'b1;
         if (hwdata[NPC_TRIG_CEOFF]) next_cur.ce_on = 1'b0;
         if (if_en && cur.state == NPC_IDLE) begin
            if (hwdata[NPC_TRIG_RD]) begin
               next_cur.state          = NPC_READ;
               next_cur.count          = '0;
               next_cur.total          = npc_total(cur.setup);
               next_cur.byte_dir_write = 1'b0;
            end else if (hwdata[NPC_TRIG_WR]) begin
               next_cur.wr_armed = 1'b1;
               next_cur.total    = npc_total(cur.setup);
            end
         end
      end

      // Block sequencer
      case (cur.state)
         NPC_IDLE: begin
            if (cur.wr_armed && tx_has_data) begin
               next_cur.wr_armed       = 1'b0;
               next_cur.state          = NPC_WRITE;
               next_cur.count          = '0;
               next_cur.byte_dir_write = 1'b1;
            end
         end
         default: begin
            if (cur.count == cur.total) begin
               next_cur.state = NPC_IDLE;
               if (cur.state == NPC_WRITE) begin
                  next_cur.wr_done    = 1'b1;
                  next_cur.wdone_flag = 1'b1;
               end else begin
                  next_cur.rd_done    = 1'b1;
                  next_cur.rdone_flag = 1'b1;
               end
            end else if (cur.byte_req) begin
               if (byte_ack) begin
                  next_cur.byte_req = 1'b0;
                  next_cur.count    = cur.count + 18'd1;
                  if (cur.setup[NPC_ECCEN_BIT] && cur.count[7:0] == NPC_ECC_LAST &&
                      cur.count < 18'(cur.setup[NPC_PAGE_LSB +: 16])) begin
                     next_cur.ecc_block_end = 1'b1;
                  end
               end
            end else if (cur.state == NPC_READ || tx_has_data) begin
               next_cur.byte_req = 1'b1;
            end
         end
      endcase

      // Disabled interface holds the sequencer at rest
      if (!if_en) begin
         next_cur.state    = NPC_IDLE;
         next_cur.byte_req = 1'b0;
         next_cur.wr_armed = 1'b0;
      end

      next_cur.pads_en = next_cur.setup[NPC_IFEN_BIT];
      next_cur.ce_n    = (next_cur.ce_on && next_cur.pads_en) ?
                         ~next_cur.timing[NPC_CSSEL_LSB +: 4] : 4'hF;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur        <= '0;
         cur.timing <= NPC_TIMING_RST;
         cur.setup  <= NPC_SETUP_RST;
         cur.ce_n   <= 4'hF;
      end else begin
         cur <= next_cur;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign hreadyout       = 1'b1;
   assign hresp           = 1'b0;
   assign hrdata          = cur.hrdata;
   assign byte_req        = cur.byte_req;
   assign byte_dir_write  = cur.byte_dir_write;
   assign ecc_active      = cur.setup[NPC_ECCEN_BIT];
   assign ecc_block_end   = cur.ecc_block_end;
   assign page_write_done = cur.wr_done;
   assign page_read_done  = cur.rd_done;
   assign ce_n            = cur.ce_n;
   assign pads_enable     = cur.pads_en;
   assign timing_cfg      = cur.timing[27:0];
   assign sread_start     = cur.sread_start;
   assign addr_start      = cur.addr_start;
   assign addr_bytes      = cur.addr_bytes;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   trig_reads_zero_a: assert property (
      acc && !hwrite && a_off == NPC_A_TRIG |=> hrdata == 32'h0000_0000)
      else $error("trigger register read back non-zero");

   sread_gated_a: assert property (
      acc && !hwrite && a_off == NPC_A_SREAD && !cur.setup[NPC_RDEN_BIT]
      |=> !sread_start && hrdata == 32'h0000_0000)
      else $error("single read launched while disabled");

   if_gates_fsm_a: assert property (
      !cur.setup[NPC_IFEN_BIT] |=> cur.state == NPC_IDLE && !byte_req
      && pads_enable == cur.setup[NPC_IFEN_BIT] && (pads_enable || ce_n == 4'hF))
      else $error("sequencer active with interface off");

   total_bytes_a: assert property (
      cur.state == NPC_IDLE && next_cur.state == NPC_READ
      |=> cur.total == npc_total($past(cur.setup)))
      else $error("block total wrong at read start");

   write_waits_a: assert property (
      cur.state == NPC_WRITE && !byte_req && !tx_has_data |=> !byte_req)
      else $error("write byte requested with empty FIFO");

   write_done_a: assert property (
      page_write_done |-> $past(cur.state) == NPC_WRITE && $past(cur.count) == $past(cur.total))
      else $error("write completion without full total");

   read_done_a: assert property (
      page_read_done |-> $past(cur.state) == NPC_READ && $past(cur.count) == $past(cur.total))
      else $error("read completion without full total");

   read_start_a: assert property (
      w_trig && hwdata[NPC_TRIG_RD] && if_en && cur.state == NPC_IDLE
      |=> cur.state == NPC_READ ##1 byte_req || cur.total == 18'd0)
      else $error("block read did not start at once");

   ce_release_a: assert property (
      w_trig && hwdata[NPC_TRIG_CEOFF] |=> ce_n == 4'hF)
      else $error("chip enable not released");

   ce_select_a: assert property (
      w_trig && hwdata[NPC_TRIG_CEON] && !hwdata[NPC_TRIG_CEOFF] && if_en
      && !(cur.wr_pend && cur.wr_addr == NPC_A_SETUP)
      |=> ce_n == ~cur.timing[NPC_CSSEL_LSB +: 4])
      else $error("chip enable not on selected chip");

   addr_count_a: assert property (
      addr_start |-> addr_bytes == $past(asize) && $past(cur.wr_pend))
      else $error("address launch count wrong");

   ecc_block_a: assert property (
      ecc_block_end |-> $past(cur.count[7:0]) == NPC_ECC_LAST && ecc_active)
      else $error("check-code block boundary misplaced");

   zero_trig_a: assert property (
      w_trig && hwdata[NPC_TRIG_WR:NPC_TRIG_CEON] == 4'h0 && cur.state == NPC_IDLE && !cur.wr_armed
      |=> $stable(ce_n) && cur.state == NPC_IDLE)
      else $error("zero trigger write had an effect");

   ce_assert_a: assert property (
      w_trig && hwdata[NPC_TRIG_CEON] && !hwdata[NPC_TRIG_CEOFF] |=> cur.ce_on)
      else $error("chip enable request not held");

   write_start_a: assert property (
      cur.wr_armed && tx_has_data && if_en && cur.state == NPC_IDLE
      |=> cur.state == NPC_WRITE && byte_dir_write)
      else $error("armed block write did not start");

endmodule // npc_page_control
`default_nettype wire

// >>> logic/npc_pkg.sv
/*
 * Constants, register map and state type of the NAND page control block.
 * Assumes an AHB-Lite register bus with 32-bit data and one hclk domain.
 */
package npc_pkg;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [7:0] NPC_A_TIMING  = 8'h0C;
   localparam logic [7:0] NPC_A_SETUP   = 8'h10;
   localparam logic [7:0] NPC_A_TRIG    = 8'h14;
   localparam logic [7:0] NPC_A_ADDR    = 8'h1C;
   localparam logic [7:0] NPC_A_ADDRX   = 8'h20;
   localparam logic [7:0] NPC_A_SREAD   = 8'h24;
   localparam logic [7:0] NPC_A_STATUS  = 8'h2C;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [31:0] NPC_TIMING_RST = 32'h0100_1000;
   localparam logic [31:0] NPC_SETUP_RST  = 32'h0000_0000;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int NPC_CSSEL_LSB   = 28;
   localparam int NPC_RDEN_BIT    = 31;
   localparam int NPC_IFEN_BIT    = 30;
   localparam int NPC_ECCEN_BIT   = 28;
   localparam int NPC_ASIZE_LSB   = 24;
   localparam int NPC_SPARE_LSB   = 16;
   localparam int NPC_PAGE_LSB    = 0;
   localparam int NPC_TRIG_WR     = 3;
   localparam int NPC_TRIG_RD     = 2;
   localparam int NPC_TRIG_CEOFF  = 1;
   localparam int NPC_TRIG_CEON   = 0;
   localparam int NPC_ST_BUSY     = 0;
   localparam int NPC_ST_WDONE    = 1;
   localparam int NPC_ST_RDONE    = 2;
   localparam int NPC_ST_CE_LSB   = 4;
   localparam int NPC_ST_CNT_LSB  = 14;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam logic [7:0] NPC_ECC_LAST   = 8'hFF;
   localparam logic [3:0] NPC_ADDR_DIRECT = 4'h4;
   localparam int          NPC_ECC_SHIFT  = 8;

   typedef enum logic [1:0] {
      NPC_IDLE  = 2'b00,
      NPC_WRITE = 2'b01,
      NPC_READ  = 2'b10
   } npc_state_t;

endpackage

// >>> testbench/npc_flash_model.sv
/*
 * Flash side model: answers byte requests and single reads.
 * Assumes the page control block holds byte_req until byte_ack is seen.
 */
`timescale 1ns/1ps
`default_nettype none
module npc_flash_model (
   // Clock and reset
   input  wire  logic        hclk,
   input  wire  logic        hresetn,
   // Byte handshake
   input  wire  logic        byte_req,
   input  wire  logic [3:0]  lat,
   output logic              byte_ack,
   // Single read
   output logic [15:0]       sread_data
);
   logic [3:0] wait_cnt;

   // Ack after lat cycles of a held request; zero lat answers at once
   assign byte_ack = byte_req && (wait_cnt >= lat);
   // Status word of a ready device
   assign sread_data = 16'h00C0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wait_cnt <= 4'h0;
      end else if (byte_req && !byte_ack) begin
         wait_cnt <= wait_cnt + 4'h1;
      end else begin
         wait_cnt <= 4'h0;
      end
   end
endmodule // npc_flash_model
`default_nettype wire

// >>> testbench/npc_page_control_tb.sv
/*
 * Self-checking bench of the NAND page control block.
 * Assumes a single AHB-Lite slave whose hreadyout drives hready.
 */
`timescale 1ns/1ps
`default_nettype none
module npc_page_control_tb;
   import npc_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, tx_has_data, byte_ack, byte_req;
   logic        byte_dir_write, ecc_active, ecc_block_end, page_write_done;
   logic        page_read_done, pads_enable, sread_start, addr_start, hreadyout, hresp;
   logic [1:0]  htrans;
   logic [3:0]  ce_n, addr_bytes, lat;
   logic [15:0] sread_data;
   logic [27:0] timing_cfg;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int          n_mismatch, samples_checked, n_ack, n_sread, n_addr, n_ecc, n_wd, n_rd, b, b2;

   npc_page_control npc_page_control_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .tx_has_data(tx_has_data), .byte_ack(byte_ack), .byte_req(byte_req),
      .byte_dir_write(byte_dir_write), .ecc_active(ecc_active),
      .ecc_block_end(ecc_block_end), .page_write_done(page_write_done),
      .page_read_done(page_read_done), .ce_n(ce_n), .pads_enable(pads_enable),
      .timing_cfg(timing_cfg), .sread_data(sread_data), .sread_start(sread_start),
      .addr_start(addr_start), .addr_bytes(addr_bytes));
   npc_flash_model npc_flash_model_i (.hclk(hclk), .hresetn(hresetn), .byte_req(byte_req),
      .lat(lat), .byte_ack(byte_ack), .sread_data(sread_data));

   // ****************************************************************
   // Clock, monitors, watchdog
   // ****************************************************************
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      n_ack   += (byte_req === 1'b1 && byte_ack === 1'b1);
      n_sread += (sread_start === 1'b1);
      n_addr  += (addr_start === 1'b1);
      n_ecc   += (ecc_block_end === 1'b1);
      n_wd    += (page_write_done === 1'b1);
      n_rd    += (page_read_done === 1'b1);
   end
   initial begin
      #200_000;
      n_mismatch++;
      stop_test();
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask

   // One AHB single transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h00_0000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
      #1;
   endtask

   function automatic logic [31:0] setup(input logic rde, ife, ecc, input logic [3:0] asz,
                                         input logic [7:0] sp, input logic [15:0] pg);
      return {rde, ife, 1'b0, ecc, asz, sp, pg};
   endfunction

   task automatic wait_pulse(ref int cnt, input int base);
      for (int i = 0; i < 3000 && cnt == base; i++) @(posedge hclk);
      #1;
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      hresetn = 1'b0; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0; haddr = '0;
      hwdata = '0; tx_has_data = 1'b0; lat = 4'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, NPC_A_SETUP, '0);  chk("setup reset", 32'h0000_0000, rd);
      bus(1'b0, 8'h30, '0);        chk("unmapped", 32'h0000_0000, rd);
      bus(1'b0, NPC_A_TIMING, '0);
      chk("timing reset", NPC_TIMING_RST, rd);
      chk("timing out", {4'h0, NPC_TIMING_RST[27:0]}, {4'h0, timing_cfg});
      chk("bus okay", 32'h0000_0001, {30'h0, hresp, hreadyout});
      chk("ce reset", 32'h0000_000F, {28'h0, ce_n});
      // Single read disabled, then enabled
      bus(1'b1, NPC_A_SETUP, setup(1'b0, 1'b1, 1'b0, 4'h3, 8'h00, 16'h0000));
      chk("pads on", 32'h1, {31'h0, pads_enable});
      b = n_sread;
      bus(1'b0, NPC_A_SREAD, '0);  chk("sread off", 32'h0, rd);
      chk("sread pulses off", b, n_sread);
      bus(1'b1, NPC_A_SETUP, setup(1'b1, 1'b1, 1'b0, 4'h3, 8'h00, 16'h0000));
      bus(1'b0, NPC_A_SREAD, '0);  chk("sread on", 32'h0000_00C0, rd);
      chk("sread pulses on", b + 1, n_sread);
      // Address launch by byte count
      b = n_addr;
      bus(1'b1, NPC_A_ADDR, 32'h1234_5678);
      @(posedge hclk);
      #1;
      chk("addr short", b + 1, n_addr);
      chk("addr bytes", 32'h3, {28'h0, addr_bytes});
      bus(1'b1, NPC_A_SETUP, setup(1'b1, 1'b1, 1'b0, 4'h5, 8'h00, 16'h0000));
      bus(1'b1, NPC_A_ADDR, 32'h1234_5678);
      chk("addr long direct", b + 1, n_addr);
      bus(1'b1, NPC_A_ADDRX, 32'h0000_0009);
      @(posedge hclk);
      #1;
      chk("addr long ext", b + 2, n_addr);
      // Chip enable on each select; zero write has no effect
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, NPC_A_TIMING, {4'(1 << k), 28'h100_1000});
         bus(1'b1, NPC_A_TRIG, 32'h0000_0001);
         chk("ce on", {28'h0, ~4'(1 << k)}, {28'h0, ce_n});
         bus(1'b1, NPC_A_TRIG, 32'h0000_0000);
         chk("ce zero write", {28'h0, ~4'(1 << k)}, {28'h0, ce_n});
         bus(1'b1, NPC_A_TRIG, 32'h0000_0002);
         chk("ce off", 32'h0000_000F, {28'h0, ce_n});
      end
      // Block read with check bytes, prompt flash; chip enabled first
      bus(1'b1, NPC_A_TIMING, {4'b0001, 28'h100_1000});
      bus(1'b1, NPC_A_TRIG, 32'h0000_0001);
      bus(1'b1, NPC_A_SETUP, setup(1'b0, 1'b1, 1'b1, 4'h3, 8'h10, 16'h0200));
      chk("ecc on", 32'h1, {31'h0, ecc_active});
      b = n_ack;
      n_ecc = 0;
      b2 = n_rd;
      bus(1'b1, NPC_A_TRIG, 32'h0000_0004);
      bus(1'b0, NPC_A_TRIG, '0);   chk("trigger reads zero", 32'h0, rd);
      wait_pulse(n_rd, b2);
      chk("read done", b2 + 1, n_rd);
      chk("read bytes", 512 + 16 + 2 * 3, n_ack - b);
      chk("ecc blocks", 2, n_ecc);
      bus(1'b0, NPC_A_STATUS, '0);
      chk("status", 32'h0085_8014, rd);
      bus(1'b1, NPC_A_STATUS, 32'h0000_0004);
      bus(1'b0, NPC_A_STATUS, '0);
      chk("status clear", 32'h0085_8010, rd);
      // Block write waits for FIFO data, slow flash
      lat = 4'h3;
      bus(1'b1, NPC_A_SETUP, setup(1'b0, 1'b1, 1'b0, 4'h3, 8'h04, 16'h0014));
      b = n_ack;
      bus(1'b1, NPC_A_TRIG, 32'h0000_0008);
      repeat (10) @(posedge hclk);
      chk("write held", b, n_ack);
      tx_has_data <= 1'b1;
      @(posedge hclk);
      #1;
      chk("write dir", 32'h1, {31'h0, byte_dir_write});
      b2 = n_wd;
      wait_pulse(n_wd, b2);
      chk("write done", b2 + 1, n_wd);
      chk("write bytes", 20 + 4, n_ack - b);
      tx_has_data <= 1'b0;
      bus(1'b1, NPC_A_TRIG, 32'h0000_0002);
      // Interface off: kicks ignored, pads off
      bus(1'b1, NPC_A_SETUP, setup(1'b0, 1'b0, 1'b0, 4'h3, 8'h04, 16'h0014));
      chk("pads off", 32'h0, {31'h0, pads_enable});
      b = n_ack;
      bus(1'b1, NPC_A_TRIG, 32'h0000_0004);
      repeat (20) @(posedge hclk);
      chk("kick ignored", b, n_ack);
      stop_test();
   end
endmodule // npc_page_control_tb
`default_nettype wire
